// [src/csd_decoder.sv]
// signal code decoder: raw frame field to logical state, value and state code
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1 - discrete field never straddles two bytes
// RULE2 - continuous valid codes normalized zero to one
// RULE3 - 2-bit: 0,1 valid, 2 error, 3 unavailable
// RULE4 - 1-byte special code minus 251, FE error
// RULE5 - 4-bit special code minus two, 14 error
// RULE6 - 2-byte special and error offset state codes
// RULE7 - 4-byte special and error offset state codes
// RULE8 - non-valid states force value to zero
// RULE9 - type selects mapping, field at byte position
// RULE10 - 1-bit both codes valid, value equals bit
// RULE11 - undefined type gives not available, zeros
module csd_decoder
	import csd_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// configuration
	input wire logic [2:0] field_type,
	input wire logic [3:0] byte_pos,
	input wire logic [3:0] bit_pos,
	// received frame, byte 1 in bits 7:0
	input wire logic frame_valid,
	input wire logic [63:0] frame_data,
	// logical signal out
	output logic out_valid,
	output logic [1:0] out_state,
	output logic [32:0] out_value,
	output logic [31:0] out_state_code,
	output logic [31:0] raw_field_code
);
	// first stage registers
	logic s1_valid_q, s1_valid_d; // stage 1 strobe
	logic [1:0] s1_state_q, s1_state_d; // stage 1 state
	logic [31:0] s1_code_q, s1_code_d; // stage 1 state code
	logic [31:0] s1_norm_code_q, s1_norm_code_d; // code to normalize
	logic [31:0] s1_scale_q, s1_scale_d; // full scale divisor
	logic s1_cont_q, s1_cont_d; // continuous valid value
	logic [31:0] s1_disc_val_q, s1_disc_val_d; // discrete value
	logic [31:0] s1_raw_q, s1_raw_d; // extracted raw code
	// output stage registers
	logic out_valid_d;
	logic [1:0] out_state_d;
	logic [32:0] out_value_d;
	logic [31:0] out_state_code_d;
	logic [31:0] raw_d;
	// helpers
	logic [32:0] fraction; // normalizer result
	logic [127:0] wide; // frame padded for byte windows
	logic [31:0] at_byte; // four bytes from byte position
	logic [7:0] sel_byte; // byte holding a discrete field
	logic [7:0] shifted; // discrete field in low bits
	logic [3:0] bidx; // zero based byte index
	logic [2:0] bbit; // zero based bit index
	csd_field_type ftype; // configured type

	// field extraction; continuous LSB at byte_pos
	always_comb begin
		ftype = csd_field_type'(field_type);
		bidx = (byte_pos == 4'h0) ? 4'h0 : byte_pos - 4'h1;
		if (bidx > 4'h7) begin
			bidx = 4'h7;
		end
		bbit = (bit_pos == 4'h0 || bit_pos > 4'h8) ? 3'h0 : 3'(bit_pos - 4'h1);
		wide = {64'h0, frame_data};
		at_byte = wide[{bidx, 3'h0} +: 32]; // RULE9
		sel_byte = at_byte[7:0]; // RULE1
		shifted = sel_byte >> bbit; // RULE1
	end

	// stage 1: classify code per type
	always_comb begin
		s1_valid_d = frame_valid;
		s1_state_d = CSD_NOT_AVAIL;
		s1_code_d = 32'h0;
		s1_norm_code_d = 32'h0;
		s1_scale_d = 32'h1;
		s1_cont_d = 1'b0;
		s1_disc_val_d = 32'h0;
		s1_raw_d = 32'h0;
		case (ftype) // RULE9
			CSD_DISC1: begin
				s1_raw_d = {31'h0, shifted[0]};
				s1_state_d = CSD_VALID; // RULE10
				s1_disc_val_d = {31'h0, shifted[0]}; // RULE10
			end
			CSD_DISC2: begin
				s1_raw_d = {30'h0, shifted[1:0]};
				if (shifted[1:0] == CSD_D2_ERROR) begin
					s1_state_d = CSD_ERROR; // RULE3
				end else if (shifted[1:0] == CSD_D2_NA) begin
					s1_state_d = CSD_NOT_AVAIL; // RULE3
				end else begin
					s1_state_d = CSD_VALID; // RULE3
					s1_disc_val_d = {30'h0, shifted[1:0]};
				end
			end
			CSD_DISC4: begin
				s1_raw_d = {28'h0, shifted[3:0]};
				if (shifted[3:0] == CSD_D4_NA) begin
					s1_state_d = CSD_NOT_AVAIL; // RULE5
				end else if (shifted[3:0] == CSD_D4_ERROR) begin
					s1_state_d = CSD_ERROR; // RULE5
				end else if (shifted[3:0] >= CSD_D4_SPEC_LO) begin
					s1_state_d = CSD_SPECIAL; // RULE5
					s1_code_d = {28'h0, shifted[3:0] - CSD_D4_SPEC_LO}; // RULE5
				end else begin
					s1_state_d = CSD_VALID;
					s1_disc_val_d = {28'h0, shifted[3:0]};
				end
			end
			CSD_CONT1: begin
				s1_raw_d = {24'h0, at_byte[7:0]};
				if (at_byte[7:0] == CSD_C1_NA) begin
					s1_state_d = CSD_NOT_AVAIL; // RULE4
				end else if (at_byte[7:0] == CSD_C1_ERROR) begin
					s1_state_d = CSD_ERROR; // RULE4
				end else if (at_byte[7:0] >= CSD_C1_SPEC_LO) begin
					s1_state_d = CSD_SPECIAL;
					s1_code_d = {24'h0, at_byte[7:0] - CSD_C1_SPEC_LO}; // RULE4
				end else begin
					s1_state_d = CSD_VALID; // RULE2
					s1_cont_d = 1'b1;
					s1_norm_code_d = {24'h0, at_byte[7:0]};
					s1_scale_d = {24'h0, CSD_C1_VALID_MAX};
				end
			end
			CSD_CONT2: begin
				s1_raw_d = {16'h0, at_byte[15:0]};
				if (at_byte[15:0] >= CSD_C2_NA_LO) begin
					s1_state_d = CSD_NOT_AVAIL; // RULE6
				end else if (at_byte[15:0] >= CSD_C2_ERR_LO) begin
					s1_state_d = CSD_ERROR;
					s1_code_d = {16'h0, at_byte[15:0] - CSD_C2_ERR_LO}; // RULE6
				end else if (at_byte[15:0] >= CSD_C2_SPEC_LO) begin
					s1_state_d = CSD_SPECIAL;
					s1_code_d = {16'h0, at_byte[15:0] - CSD_C2_SPEC_LO}; // RULE6
				end else begin
					s1_state_d = CSD_VALID; // RULE2
					s1_cont_d = 1'b1;
					s1_norm_code_d = {16'h0, at_byte[15:0]};
					s1_scale_d = {16'h0, CSD_C2_VALID_MAX};
				end
			end
			CSD_CONT4: begin
				s1_raw_d = at_byte;
				if (at_byte >= CSD_C4_NA_LO) begin
					s1_state_d = CSD_NOT_AVAIL; // RULE7
				end else if (at_byte >= CSD_C4_ERR_LO) begin
					s1_state_d = CSD_ERROR;
					s1_code_d = at_byte - CSD_C4_ERR_LO; // RULE7
				end else if (at_byte >= CSD_C4_SPEC_LO) begin
					s1_state_d = CSD_SPECIAL;
					s1_code_d = at_byte - CSD_C4_SPEC_LO; // RULE7
				end else begin
					s1_state_d = CSD_VALID; // RULE2
					s1_cont_d = 1'b1;
					s1_norm_code_d = at_byte;
					s1_scale_d = CSD_C4_VALID_MAX;
				end
			end
			default: begin
				// undefined type: not available, zeros
				s1_state_d = CSD_NOT_AVAIL; // RULE11
			end
		endcase
	end

	// stage 1 registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s1_valid_q <= 1'b0;
			s1_state_q <= CSD_NOT_AVAIL;
			s1_code_q <= CSD_RESET_WORD;
			s1_norm_code_q <= CSD_RESET_WORD;
			s1_scale_q <= 32'h1;
			s1_cont_q <= 1'b0;
			s1_disc_val_q <= CSD_RESET_WORD;
			s1_raw_q <= CSD_RESET_WORD;
		end else begin
			s1_valid_q <= s1_valid_d;
			s1_state_q <= s1_state_d;
			s1_code_q <= s1_code_d;
			s1_norm_code_q <= s1_norm_code_d;
			s1_scale_q <= s1_scale_d;
			s1_cont_q <= s1_cont_d;
			s1_disc_val_q <= s1_disc_val_d;
			s1_raw_q <= s1_raw_d;
		end
	end

	// normalizer, its result lines up with stage 2 input
	csd_norm u_norm (
		.clock(clock),
		.reset(reset),
		.code(s1_norm_code_q),
		.full_scale(s1_scale_q),
		.fraction(fraction)
	);

	// delayed stage 1 results wait for the divider
	logic s2_valid_q;
	logic [1:0] s2_state_q;
	logic [31:0] s2_code_q, s2_disc_q, s2_raw_q;
	logic s2_cont_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s2_valid_q <= 1'b0;
			s2_state_q <= CSD_NOT_AVAIL;
			s2_code_q <= CSD_RESET_WORD;
			s2_disc_q <= CSD_RESET_WORD;
			s2_raw_q <= CSD_RESET_WORD;
			s2_cont_q <= 1'b0;
		end else begin
			s2_valid_q <= s1_valid_q;
			s2_state_q <= s1_state_q;
			s2_code_q <= s1_code_q;
			s2_disc_q <= s1_disc_val_q;
			s2_raw_q <= s1_raw_q;
			s2_cont_q <= s1_cont_q;
		end
	end

	// final value; holds last result between frames
	always_comb begin
		out_valid_d = s2_valid_q;
		out_state_d = out_state;
		out_value_d = out_value;
		out_state_code_d = out_state_code;
		raw_d = raw_field_code;
		if (s2_valid_q) begin
			out_state_d = s2_state_q;
			out_state_code_d = s2_code_q;
			raw_d = s2_raw_q;
			if (s2_state_q != CSD_VALID) begin
				out_value_d = 33'h0; // RULE8
			end else if (s2_cont_q) begin
				out_value_d = fraction; // RULE2
			end else begin
				out_value_d = {s2_disc_q[0], 32'h0}; // RULE10
			end
		end
	end

	// output registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_state <= CSD_NOT_AVAIL;
			out_value <= 33'h0;
			out_state_code <= CSD_RESET_WORD;
			raw_field_code <= CSD_RESET_WORD;
		end else begin
			out_valid <= out_valid_d;
			out_state <= out_state_d;
			out_value <= out_value_d;
			out_state_code <= out_state_code_d;
			raw_field_code <= raw_d;
		end
	end
endmodule
`default_nettype wire

// [src/csd_norm.sv]
// normalizer: valid continuous code divided by its largest valid code
`timescale 1ns/10ps
`default_nettype none
module csd_norm
	import csd_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// code and its divisor
	input wire logic [31:0] code,
	input wire logic [31:0] full_scale,
	// registered fraction, 1.32 fixed point, saturates at one
	output logic [32:0] fraction
);
	logic [32:0] fraction_d; // combinational quotient
	logic [63:0] numer; // code shifted up for the fraction bits
	logic [63:0] quot; // raw quotient

	// divide code by full scale; one clock latency
	always_comb begin
		numer = {code, 32'h0};
		quot = (full_scale == 32'h0) ? 64'h0 : numer / {32'h0, full_scale};
		if (quot > 64'h0000000100000000) begin
			fraction_d = 33'h100000000; // clip at one
		end else begin
			fraction_d = quot[32:0];
		end
	end

	// result register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fraction <= 33'h0;
		end else begin
			fraction <= fraction_d;
		end
	end
endmodule
`default_nettype wire

// [src/csd_pkg.sv]
// package for the signal code decoder: field types, states, code boundaries
package csd_pkg;
	// configured field type
	typedef enum logic [2:0] {
		CSD_UNDEFINED = 3'h0,
		CSD_DISC1 = 3'h1,
		CSD_DISC2 = 3'h2,
		CSD_DISC4 = 3'h3,
		CSD_CONT1 = 3'h4,
		CSD_CONT2 = 3'h5,
		CSD_CONT4 = 3'h6
	} csd_field_type;

	// decoded logical state
	typedef enum logic [1:0] {
		CSD_VALID = 2'h0,
		CSD_SPECIAL = 2'h1,
		CSD_ERROR = 2'h2,
		CSD_NOT_AVAIL = 2'h3
	} csd_state_type;

	// output widths
	localparam int CSD_VALUE_W = 32;
	localparam int CSD_FRAC_W = 32;

	// 2-bit discrete codes
	localparam logic [1:0] CSD_D2_ERROR = 2'h2;
	localparam logic [1:0] CSD_D2_NA = 2'h3;
	// 4-bit discrete codes
	localparam logic [3:0] CSD_D4_SPEC_LO = 4'h2;
	localparam logic [3:0] CSD_D4_SPEC_HI = 4'hd;
	localparam logic [3:0] CSD_D4_ERROR = 4'he;
	localparam logic [3:0] CSD_D4_NA = 4'hf;
	// 1-byte continuous codes
	localparam logic [7:0] CSD_C1_VALID_MAX = 8'hfa;
	localparam logic [7:0] CSD_C1_SPEC_LO = 8'hfb;
	localparam logic [7:0] CSD_C1_SPEC_HI = 8'hfd;
	localparam logic [7:0] CSD_C1_ERROR = 8'hfe;
	localparam logic [7:0] CSD_C1_NA = 8'hff;
	// 2-byte continuous codes
	localparam logic [15:0] CSD_C2_VALID_MAX = 16'hfaff;
	localparam logic [15:0] CSD_C2_SPEC_LO = 16'hfb00;
	localparam logic [15:0] CSD_C2_ERR_LO = 16'hfe00;
	localparam logic [15:0] CSD_C2_NA_LO = 16'hff00;
	// 4-byte continuous codes
	localparam logic [31:0] CSD_C4_VALID_MAX = 32'hfaffffff;
	localparam logic [31:0] CSD_C4_SPEC_LO = 32'hfb000000;
	localparam logic [31:0] CSD_C4_ERR_LO = 32'hfe000000;
	localparam logic [31:0] CSD_C4_NA_LO = 32'hff000000;

	// reset value of the outputs, and the highest byte position
	localparam logic [31:0] CSD_RESET_WORD = 32'h0;
	localparam logic [7:0] CSD_BYTE_POS_MAX = 8'h8;
endpackage

// [tb/csd_decoder_properties.sv]
// checker for the signal code decoder ports
`timescale 1ns/10ps
`default_nettype none
module csd_decoder_properties
	import csd_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// frame side
	input wire logic [2:0] field_type,
	input wire logic frame_valid,
	// logical signal
	input wire logic out_valid,
	input wire logic [1:0] out_state,
	input wire logic [32:0] out_value,
	input wire logic [31:0] out_state_code,
	input wire logic [31:0] raw_field_code
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (reset);
	// one answer per frame, three cycles on
	property p_lat; out_valid == $past(frame_valid, 3); endproperty
	a_lat: assert property (p_lat) else $error("answer timing wrong");
	property p_zero; out_valid && out_state != CSD_VALID |-> out_value == 33'h0; endproperty
	a_zero: assert property (p_zero) else $error("value not zero");
	property p_d1; out_valid && $past(field_type, 3) == CSD_DISC1 |->
		out_state == CSD_VALID && out_value == {raw_field_code[0], 32'h0}; endproperty
	a_d1: assert property (p_d1) else $error("1-bit wrong");
	property p_d2; out_valid && $past(field_type, 3) == CSD_DISC2 && raw_field_code[1] |->
		out_state == raw_field_code[1:0] && out_state_code == 32'h0; endproperty
	a_d2: assert property (p_d2) else $error("2-bit wrong");
	property p_d4; out_valid && $past(field_type, 3) == CSD_DISC4 && raw_field_code[3:0] inside {[4'h2:4'hd]} |->
		out_state == CSD_SPECIAL && out_state_code == raw_field_code - 32'h2; endproperty
	a_d4: assert property (p_d4) else $error("4-bit wrong");
	property p_c1; out_valid && $past(field_type, 3) == CSD_CONT1 && raw_field_code[7:0] inside {[8'hfb:8'hfd]} |->
		out_state == CSD_SPECIAL && out_state_code == raw_field_code - 32'hfb; endproperty
	a_c1: assert property (p_c1) else $error("1-byte wrong");
	property p_c2; out_valid && $past(field_type, 3) == CSD_CONT2 && raw_field_code[15:8] == 8'hfe |->
		out_state == CSD_ERROR && out_state_code == raw_field_code - 32'hfe00; endproperty
	a_c2: assert property (p_c2) else $error("2-byte wrong");
	property p_c4; out_valid && $past(field_type, 3) == CSD_CONT4 && raw_field_code[31:24] inside {[8'hfb:8'hfd]} |->
		out_state == CSD_SPECIAL && out_state_code == raw_field_code - 32'hfb000000; endproperty
	a_c4: assert property (p_c4) else $error("4-byte wrong");
	property p_undef; out_valid && $past(field_type, 3) inside {3'h0, 3'h7} |->
		out_state == CSD_NOT_AVAIL && out_value == 33'h0 && out_state_code == 32'h0; endproperty
	a_undef: assert property (p_undef) else $error("undefined wrong");
	// main scenarios reached
	c_special: cover property (out_valid && out_state == CSD_SPECIAL);
	c_error: cover property (out_valid && out_state == CSD_ERROR);
	c_back: cover property (out_valid ##1 out_valid);
endmodule
bind csd_decoder csd_decoder_properties u_props (.clock(clock), .reset(reset), .field_type(field_type),
	.frame_valid(frame_valid), .out_valid(out_valid), .out_state(out_state), .out_value(out_value),
	.out_state_code(out_state_code), .raw_field_code(raw_field_code));
`default_nettype wire

// [tb/csd_frame_src.sv]
// upstream field source model: frame pulses and configuration
`timescale 1ns/10ps
`default_nettype none
module csd_frame_src (
	// clock
	input wire logic clock,
	// toward the decoder
	output var logic [2:0] field_type,
	output var logic [3:0] byte_pos,
	output var logic [3:0] bit_pos,
	output var logic frame_valid,
	output var logic [63:0] frame_data
);
	// quiet at time zero
	initial begin
		field_type = 3'h0;
		byte_pos = 4'h1;
		bit_pos = 4'h1;
		frame_valid = 1'b0;
		frame_data = 64'h0;
	end
	// one frame at the falling edge; discrete fields stay inside one byte
	task automatic send(input logic [2:0] ft, input logic [3:0] bp, input logic [3:0] bt, input logic [63:0] d);
		@(negedge clock);
		field_type = ft;
		byte_pos = bp;
		bit_pos = bt;
		frame_data = d;
		frame_valid = 1'b1;
	endtask
	// drop the pulse, scramble data so stale bytes never match
	task automatic idle();
		@(negedge clock);
		frame_valid = 1'b0;
		frame_data = ~frame_data;
	endtask
endmodule
`default_nettype wire

// [tb/test_can_signal_code_decoder.sv]
// testbench for the signal code decoder
`timescale 1ns/10ps
`default_nettype none
module test_can_signal_code_decoder import csd_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [2:0] field_type;
	logic [3:0] byte_pos;
	logic [3:0] bit_pos;
	logic frame_valid;
	logic [63:0] frame_data;
	logic out_valid;
	logic [1:0] out_state;
	logic [32:0] out_value;
	logic [31:0] out_state_code;
	logic [31:0] raw_field_code;
	int n_fail = 0;
	int check_count = 0;
	// 250 MHz
	always #2 clock = ~clock;
	csd_frame_src src (.clock(clock), .field_type(field_type), .byte_pos(byte_pos), .bit_pos(bit_pos),
		.frame_valid(frame_valid), .frame_data(frame_data));
	csd_decoder uut (.clock(clock), .reset(reset), .field_type(field_type), .byte_pos(byte_pos),
		.bit_pos(bit_pos), .frame_valid(frame_valid), .frame_data(frame_data), .out_valid(out_valid),
		.out_state(out_state), .out_value(out_value), .out_state_code(out_state_code),
		.raw_field_code(raw_field_code));
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// field of w bits at byte bp, bit offset sh; all other bits ones
	function automatic logic [63:0] put(input int bp, input int sh, input int w, input logic [31:0] c);
		logic [63:0] m;
		m = ((64'h1 << w) - 64'h1) << (8 * (bp - 1) + sh);
		return ~m | (({32'h0, c} << (8 * (bp - 1) + sh)) & m);
	endfunction
	// expected logical signal from type and raw code
	function automatic void expect_of(input logic [2:0] ft, input logic [31:0] r, output logic [1:0] st,
		output logic [32:0] v, output logic [31:0] sc);
		int sh;
		logic [31:0] sp;
		logic [31:0] er;
		logic [31:0] na;
		logic [63:0] q;
		st = CSD_VALID;
		v = {r[0], 32'h0};
		sc = 32'h0;
		sh = (ft == CSD_CONT1) ? 24 : (ft == CSD_CONT2) ? 16 : 0;
		sp = 32'hfb000000 >> sh;
		er = 32'hfe000000 >> sh;
		na = (ft == CSD_DISC2) ? 32'h3 : (ft == CSD_DISC4) ? 32'hf : 32'hff000000 >> sh;
		case (ft)
			CSD_DISC1: st = CSD_VALID;
			CSD_DISC2, CSD_DISC4: begin
				if (r >= na - 32'h1) st = (r == na) ? CSD_NOT_AVAIL : CSD_ERROR;
				else if (r >= 32'h2) begin
					st = CSD_SPECIAL;
					sc = r - 32'h2;
				end
			end
			CSD_CONT1, CSD_CONT2, CSD_CONT4: begin
				q = {r, 32'h0} / {32'h0, sp - 32'h1};
				v = (q > 64'h100000000) ? 33'h100000000 : q[32:0];
				if (r >= na) st = CSD_NOT_AVAIL;
				else if (r >= er) begin
					st = CSD_ERROR;
					sc = r - er;
				end else if (r >= sp) begin
					st = CSD_SPECIAL;
					sc = r - sp;
				end
			end
			default: st = CSD_NOT_AVAIL;
		endcase
		if (st != CSD_VALID) v = 33'h0;
	endfunction
	task automatic expect_out(input logic [2:0] ft, input logic [31:0] r, input int lim);
		logic [1:0] st;
		logic [32:0] v;
		logic [31:0] sc;
		int n;
		n = 0;
		expect_of(ft, r, st, v, sc);
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (out_valid !== 1'b1 && n < lim);
		check("valid", out_valid, 1'b1);
		check("state", out_state, st);
		check("value", out_value, v);
		check("code", out_state_code, sc);
		check("raw", raw_field_code, r);
	endtask
	task automatic frame(input logic [2:0] ft, input int bp, input int bt, input logic [63:0] d, input logic [31:0] r);
		src.send(ft, bp[3:0], bt[3:0], d);
		src.idle();
		expect_out(ft, r, 8);
	endtask
	task automatic t_reset;
		check("valid", out_valid, 1'b0);
		check("state", out_state, CSD_NOT_AVAIL);
		check("value", out_value, 33'h0);
		check("code", out_state_code, 32'h0);
		check("raw", raw_field_code, 32'h0);
		$display("done t_reset");
	endtask
	// every code of every discrete width, other bits set
	task automatic t_discrete;
		int bp [3] = '{3, 2, 8};
		int bt [3] = '{5, 7, 5};
		for (int k = 0; k < 3; k++) begin
			for (int c = 0; c < (1 << (1 << k)); c++) begin
				frame(3'(k + 1), bp[k], bt[k], put(bp[k], bt[k] - 1, 1 << k, c), c);
			end
		end
		$display("done t_discrete");
	endtask
	// range boundaries of each continuous width
	task automatic t_continuous;
		int bp [3] = '{4, 7, 1};
		int sh [3] = '{24, 16, 0};
		logic [31:0] mx;
		logic [31:0] er;
		logic [31:0] na;
		logic [31:0] cs [10];
		for (int k = 0; k < 3; k++) begin
			mx = 32'hfaffffff >> sh[k];
			er = 32'hfe000000 >> sh[k];
			na = 32'hff000000 >> sh[k];
			cs = '{32'h0, mx >> 1, mx, mx + 32'h1, er - 32'h1, er, er + 32'h1, na - 32'h1, na, 32'hffffffff >> sh[k]};
			foreach (cs[i]) frame(3'(k + 4), bp[k], 1, put(bp[k], 0, 32 - sh[k], cs[i]), cs[i]);
		end
		frame(CSD_CONT4, 6, 1, put(6, 0, 32, 32'h12c0ffee), 32'h00c0ffee);
		$display("done t_continuous");
	endtask
	task automatic t_undef;
		frame(CSD_UNDEFINED, 2, 3, ~64'h0, 32'h0);
		frame(3'h7, 5, 1, 64'h0123456789abcdef, 32'h0);
		$display("done t_undef");
	endtask
	// two frames on adjacent edges, type changing between them
	task automatic t_back;
		src.send(CSD_CONT2, 4'h7, 4'h1, put(7, 0, 16, 32'hfe01));
		src.send(CSD_DISC4, 4'h1, 4'h5, put(1, 4, 4, 32'h9));
		src.idle();
		expect_out(CSD_CONT2, 32'hfe01, 8);
		expect_out(CSD_DISC4, 32'h9, 1);
		$display("done t_back");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		t_reset;
		t_discrete;
		t_continuous;
		t_undef;
		t_back;
		end_of_test;
	end
	// hang guard, well past the expected run
	initial begin
		#40000;
		n_fail++;
		end_of_test;
	end
endmodule
`default_nettype wire
